/* File: dls_line_status.sv */
`timescale 1ns/1ps
`include "dls_defines.svh"

module dls_line_status #(
	parameter int QW = 16,
	parameter int BRK_UNIT_CYC = `DLS_BRK_UNIT_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [4:0] modem_in_i,
	output logic [7:0] modem_out_o,
	output logic break_o,
	output logic [7:0] tx_data_o,
	output logic tx_valid_o,
	output dls_pkg::dls_link_cmd_t link_cmd_o,
	input wire dls_pkg::dls_rd_end_t rd_end_i,
	input wire logic inbound_block_i,
	input wire logic [QW-1:0] q_free_i
);
	import dls_pkg::*;

	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	generate
		if (QW < 8 || QW > 24) begin : g_bad_qw
			$error("Queue width must lie between 8 and 24 bits.");
		end
		if (BRK_UNIT_CYC < 1 || BRK_UNIT_CYC > 4095) begin : g_bad_unit
			$error("Break unit must lie between 1 and 4095 cycles.");
		end
		if (BRK_UNIT_CYC * 255 > 20'hfffff) begin : g_bad_span
			$error("Longest break must fit the 20-bit break counter.");
		end
	endgenerate

	localparam logic [19:0] UNIT = 20'(BRK_UNIT_CYC);
	localparam logic [QW-1:0] Q_RESERVE =
		QW'(`DLS_CB_RESERVE * `DLS_CB_BYTES);
	localparam logic [QW-1:0] Q_CAP = QW'(8'hff);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------

	// Queue space is saturated to the 8-bit register; a queue that cannot
	// take three more control blocks is reported as full.
	function automatic logic [7:0] q_space(input logic [QW-1:0] free);
		logic [7:0] r;
		r = 8'h00;
		if (free < Q_RESERVE) begin
			r = 8'h00;
		end else if (free > Q_CAP) begin
			r = 8'hff;
		end else begin
			r = free[7:0];
		end
		return r;
	endfunction

	// True when a taken write lands on the given register index.
	function automatic logic hits(input logic w, input logic [5:0] a,
		input logic [5:0] target);
		return w && (a == target);
	endfunction

	// Break length in clock cycles; a length of zero is served as one
	// unit, so a break request is never dropped.
	function automatic logic [19:0] brk_cycles(input logic [7:0] len);
		logic [19:0] r;
		r = UNIT;
		if (len != 8'h00) begin
			r = 20'(len * UNIT);
		end
		return r;
	endfunction

	// Encodes the block that ended a read into type (high byte) and mode.
	function automatic logic [15:0] cb_encode(input dls_rd_end_t e,
		input logic link, input logic subst);
		logic [15:0] r;
		r = {`DLS_CB_NONE, `DLS_MODE_NONE};
		// Async mode reports line events; link mode reports block ends.
		if (!link) begin
			case (e.kind)
			DLS_RX_BREAK: begin
				r = {`DLS_CB_BREAK, `DLS_MODE_NONE};
			end
			DLS_RX_FRAME: begin
				if (!subst) begin
					r = {`DLS_CB_ERROR, `DLS_MODE_FRAME};
				end
			end
			DLS_RX_PARITY: begin
				if (!subst) begin
					r = {`DLS_CB_ERROR, `DLS_MODE_PARITY};
				end
			end
			DLS_RX_FRPAR: begin
				if (!subst) begin
					r = {`DLS_CB_ERROR, `DLS_MODE_FRPAR};
				end
			end
			DLS_RX_EOL: begin
				r = {`DLS_CB_EOL, `DLS_MODE_ONE};
			end
			DLS_RX_PROMPT: begin
				r = {`DLS_CB_PROMPT, `DLS_MODE_ONE};
			end
			default: begin
				r = {`DLS_CB_NONE, `DLS_MODE_NONE};
			end
			endcase
		end else begin
			case (e.kind)
			DLS_RX_ETB: begin
				r = {`DLS_CB_BLK_END, `DLS_MODE_ETB};
			end
			DLS_RX_ETX: begin
				r = {`DLS_CB_BLK_END, `DLS_MODE_ETX};
			end
			DLS_RX_HEADER: begin
				// Mode bit 3 set marks the command channel.
				r = {`DLS_CB_HEADER, 4'h0, e.cmd_chan, e.select,
					e.transparent};
			end
			default: begin
				r = {`DLS_CB_NONE, `DLS_MODE_NONE};
			end
			endcase
		end
		return r;
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	// All state lives in one struct, so reset and hold treat it alike.
	dls_state_t s_q;
	dls_state_t s_d;

	logic [5:0] idx;
	logic req;
	logic wr;
	logic brk_wr;
	logic link;
	logic half;
	logic conn;
	logic [19:0] brk_total;
	logic [15:0] cb_code;
	logic rts_now;

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	// A request is taken only while the acknowledge is low, so a master
	// that holds its strobe through the acknowledge is served once.
	assign idx = wb_adr_i[7:2];
	assign req = wb_cyc_i & wb_stb_i & ~s_q.ack;
	assign wr = req & wb_we_i & wb_sel_i[0];
	assign brk_wr = hits(wr, idx, `DLS_IDX_BREAK);
	assign link = s_q.cfg[`DLS_CFG_LINK];
	assign half = s_q.cfg[`DLS_CFG_HALF];
	assign conn = s_q.cfg[`DLS_CFG_CONN];
	assign brk_total = brk_cycles(s_q.brk_len);
	// Substitution hides error blocks but leaves break reports intact.
	assign cb_code = cb_encode(rd_end_i, link, s_q.cfg[`DLS_CFG_SUBST]);
	// In half duplex the software RTS bit is ignored and only the
	// transfer latch drives the line.
	assign rts_now = half ? s_q.rts_hd : s_q.drv[`DLS_DRV_RTS];

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		// The acknowledge follows every taken request by one cycle.
		s_d.ack = req;
		// Link commands and the transmit strobe are one-cycle pulses.
		s_d.tx_valid = 1'b0;
		s_d.cmd = '0;

		// Read data is captured with the acknowledge; unmapped reads 0.
		// Reads have no side effects, so a repeated read is harmless.
		if (req && !wb_we_i) begin
			case (idx)
			`DLS_IDX_BREAK: begin
				s_d.rdata = {7'h00, s_q.brk_st == DLS_BRK_RUN};
			end
			`DLS_IDX_MDM_IN: begin
				s_d.rdata = {3'h0, modem_in_i};
			end
			`DLS_IDX_MDM_OUT: begin
				s_d.rdata = s_q.mdm_out;
			end
			`DLS_IDX_CB_TYPE: begin
				s_d.rdata = s_q.cb_type;
			end
			`DLS_IDX_CB_MODE: begin
				s_d.rdata = s_q.cb_mode;
			end
			`DLS_IDX_Q_SPACE: begin
				s_d.rdata = q_space(q_free_i);
			end
			`DLS_IDX_DRV_CTRL: begin
				s_d.rdata = s_q.drv;
			end
			`DLS_IDX_CONFIG: begin
				s_d.rdata = {4'h0, s_q.cfg};
			end
			`DLS_IDX_BRK_LEN: begin
				s_d.rdata = s_q.brk_len;
			end
			default: begin
				s_d.rdata = 8'h00;
			end
			endcase
		end

		// Writes with byte lane 0 disabled are acknowledged but change
		// nothing, as every register lives in that lane.
		if (wr) begin
			case (idx)
			`DLS_IDX_TERM: begin
				// A full-duplex async line keeps the line: no action.
				if (link) begin
					s_d.cmd.term_block = 1'b1;
				end else if (half) begin
					s_d.cmd.turnaround = 1'b1;
					s_d.rts_hd = 1'b0;
				end
			end
			`DLS_IDX_BREAK: begin
				// The written value carries no meaning. In link mode a waiting inbound
				// block takes the reply; otherwise the next outbound block
				// carries the substitute character.
				if (link) begin
					if (inbound_block_i) begin
						s_d.cmd.reverse_interrupt_reply = 1'b1;
					end else begin
						s_d.cmd.substitute_control_char = 1'b1;
					end
				end else begin
					s_d.brk_st = DLS_BRK_RUN;
					s_d.brk_cnt = brk_total;
				end
			end
			`DLS_IDX_TX_DATA: begin
				// Each outbound byte reclaims the line; in full duplex the
				// latch is held but not used.
				s_d.tx_data = wb_dat_i[7:0];
				s_d.tx_valid = 1'b1;
				s_d.rts_hd = 1'b1;
			end
			`DLS_IDX_DRV_CTRL: begin
				s_d.drv = wb_dat_i[7:0];
			end
			`DLS_IDX_CONFIG: begin
				s_d.cfg = wb_dat_i[3:0];
			end
			`DLS_IDX_BRK_LEN: begin
				s_d.brk_len = wb_dat_i[7:0];
			end
			default: begin
			end
			endcase
		end

		// A break already running is restarted by a new request above;
		// otherwise it counts down and clears pending on its own. The
		// counter is loaded with the full length, the line follows one
		// cycle later and is held for exactly that many cycles, so
		// pending and the line clear at the same edge.
		case (s_q.brk_st)
		DLS_BRK_IDLE: begin
			s_d.break_out = 1'b0;
		end
		DLS_BRK_RUN: begin
			s_d.break_out = 1'b1;
			if (!brk_wr) begin
				if (s_q.brk_cnt == 20'h00000) begin
					s_d.brk_st = DLS_BRK_IDLE;
					s_d.break_out = 1'b0;
					s_d.brk_cnt = 20'h00000;
				end else begin
					s_d.brk_cnt = s_q.brk_cnt - 20'h00001;
				end
			end
		end
		default: begin
			s_d.brk_st = DLS_BRK_IDLE;
		end
		endcase

		if (rd_end_i.done) begin
			s_d.cb_type = cb_code[15:8];
			s_d.cb_mode = cb_code[7:0];
		end

		// Until the line is connected every driver stays inactive.
		// The image lags the control registers by one cycle, which keeps
		// the port straight from a flip-flop.
		if (conn) begin
			s_d.mdm_out = {s_q.drv[7:1], rts_now};
		end else begin
			s_d.mdm_out = `DLS_RST_DRV;
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	// Reset is synchronous; the struct is cleared first and the fields
	// with named reset values are then set.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.brk_st <= DLS_BRK_IDLE;
			s_q.drv <= `DLS_RST_DRV;
			s_q.cfg <= `DLS_RST_CFG;
			s_q.brk_len <= `DLS_RST_BRK_LEN;
			// The latch starts set, so a half-duplex async line belongs to this
			// side until the first terminate gives it up.
			s_q.rts_hd <= 1'b1;
			s_q.cb_type <= `DLS_CB_NONE;
			s_q.cb_mode <= `DLS_MODE_NONE;
			s_q.mdm_out <= `DLS_RST_DRV;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign wb_ack_o = s_q.ack;
	// No register is wider than eight bits, so the upper lanes read zero.
	assign wb_dat_o = {24'h000000, s_q.rdata};
	assign modem_out_o = s_q.mdm_out;
	assign break_o = s_q.break_out;
	assign tx_data_o = s_q.tx_data;
	assign tx_valid_o = s_q.tx_valid;
	assign link_cmd_o = s_q.cmd;

endmodule

/* File: dls_defines.svh */
`ifndef DLS_DEFINES_SVH
`define DLS_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define DLS_IDX_TERM 6'h05
`define DLS_IDX_BREAK 6'h06
`define DLS_IDX_MDM_IN 6'h07
`define DLS_IDX_MDM_OUT 6'h08
`define DLS_IDX_CB_TYPE 6'h09
`define DLS_IDX_CB_MODE 6'h0a
`define DLS_IDX_Q_SPACE 6'h0b
`define DLS_IDX_TX_DATA 6'h20
`define DLS_IDX_DRV_CTRL 6'h21
`define DLS_IDX_CONFIG 6'h22
`define DLS_IDX_BRK_LEN 6'h27

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DLS_CFG_LINK 0
`define DLS_CFG_HALF 1
`define DLS_CFG_CONN 2
`define DLS_CFG_SUBST 3
`define DLS_DRV_RTS 0
`define DLS_DRV_DTR 1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DLS_RST_DRV 8'h00
`define DLS_RST_CFG 4'h0
`define DLS_RST_BRK_LEN 8'h01

// ----------------------------------------------------------------------
// Control block codes
// ----------------------------------------------------------------------
`define DLS_CB_NONE 8'h00
`define DLS_CB_BREAK 8'hfa
`define DLS_CB_ERROR 8'hfb
`define DLS_CB_EOL 8'hfc
`define DLS_CB_PROMPT 8'hfd
`define DLS_CB_HEADER 8'hfd
`define DLS_CB_BLK_END 8'hfe
`define DLS_MODE_NONE 8'h00
`define DLS_MODE_ONE 8'h01
`define DLS_MODE_FRAME 8'h01
`define DLS_MODE_PARITY 8'h02
`define DLS_MODE_FRPAR 8'h03
`define DLS_MODE_ETB 8'h01
`define DLS_MODE_ETX 8'h02

// ----------------------------------------------------------------------
// Queue reserve and timing
// ----------------------------------------------------------------------
`define DLS_CB_BYTES 2
`define DLS_CB_RESERVE 3
`define DLS_CLK_PERIOD_NS 5
`define DLS_BRK_UNIT_NS 10000
`define DLS_BRK_UNIT_CYC (`DLS_BRK_UNIT_NS / `DLS_CLK_PERIOD_NS)

`endif

/* File: dls_pkg.sv */
package dls_pkg;

	typedef enum logic [3:0] {
		DLS_RX_NONE,
		DLS_RX_BREAK,
		DLS_RX_FRAME,
		DLS_RX_PARITY,
		DLS_RX_FRPAR,
		DLS_RX_EOL,
		DLS_RX_PROMPT,
		DLS_RX_ETB,
		DLS_RX_ETX,
		DLS_RX_HEADER
	} dls_rx_kind_t;

	// Report from the receive path when a host read ends.
	typedef struct packed {
		logic done;
		dls_rx_kind_t kind;
		logic transparent;
		logic [1:0] select;
		logic cmd_chan;
	} dls_rd_end_t;

	// One-cycle commands to the serial_io_engine.
	typedef struct packed {
		logic term_block;
		logic reverse_interrupt_reply;
		logic substitute_control_char;
		logic turnaround;
	} dls_link_cmd_t;

	typedef enum logic {
		DLS_BRK_IDLE,
		DLS_BRK_RUN
	} dls_brk_state_t;

	typedef struct packed {
		logic ack;
		logic [7:0] rdata;
		dls_brk_state_t brk_st;
		logic [19:0] brk_cnt;
		logic break_out;
		logic [7:0] drv;
		logic [3:0] cfg;
		logic [7:0] brk_len;
		logic rts_hd;
		logic [7:0] cb_type;
		logic [7:0] cb_mode;
		logic [7:0] tx_data;
		logic tx_valid;
		dls_link_cmd_t cmd;
		logic [7:0] mdm_out;
	} dls_state_t;

endpackage

/* File: dls_line_status_props.sv */
`timescale 1ns/1ps
module dls_line_status_props #(
	parameter int QW = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [4:0] modem_in_i,
	input wire logic break_o,
	input wire logic [7:0] tx_data_o,
	input wire logic tx_valid_o,
	input wire dls_pkg::dls_link_cmd_t link_cmd_o,
	input wire logic [QW-1:0] q_free_i
);
	import dls_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	function automatic logic [31:0] qx(logic [QW-1:0] f);
		return f < 6 ? 32'h0 : f > 255 ? 32'hff : 32'(f);
	endfunction
	logic rd_q;
	assign rd_q = wb_ack_o && !wb_we_i;
	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	AST_RD_HIGH: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper data set");
	AST_MDM_IN: assert property (rd_q && wb_adr_i[7:2] == 6'h07 |->
		wb_dat_o == {27'h0, $past(modem_in_i)}) else $error("modem in");
	AST_QSPACE: assert property (rd_q && wb_adr_i[7:2] == 6'h0b |->
		wb_dat_o == qx($past(q_free_i))) else $error("queue space");
	AST_PEND: assert property (rd_q && wb_adr_i[7:2] == 6'h06 &&
		$past(break_o) |-> wb_dat_o == 32'h1) else $error("pending");
	AST_BRK_CAUSE: assert property ($rose(break_o) |->
		$past(wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h06))
		else $error("break start");
	AST_TX_CAUSE: assert property (tx_valid_o |-> $past(wb_cyc_i &&
		wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == 6'h20) &&
		tx_data_o == $past(wb_dat_i[7:0])) else $error("tx pulse");
	AST_CMD_CAUSE: assert property (link_cmd_o != 4'h0 |->
		$onehot(link_cmd_o) && $past(wb_we_i && wb_sel_i[0] &&
		wb_adr_i[7:2] inside {6'h05, 6'h06})) else $error("link cmd");
endmodule
bind dls_line_status dls_line_status_props #(.QW(QW)) i_props(.*);

/* File: dls_modem_model.sv */
`timescale 1ns/1ps
// ----
// Far side: line inputs and receive reports, one register stage.
// ----
module dls_modem_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire dls_pkg::dls_rd_end_t ev_i,
	input wire logic [4:0] mdm_i,
	input wire logic [15:0] qf_i,
	input wire logic ib_i,
	output dls_pkg::dls_rd_end_t rd_end_o,
	output logic [4:0] modem_in_o,
	output logic [15:0] q_free_o,
	output logic inbound_block_o
);
	import dls_pkg::*;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_end_o <= '0;
			modem_in_o <= 5'h0;
			q_free_o <= 16'h0;
			inbound_block_o <= 1'b0;
		end else begin
			rd_end_o <= ev_i;
			modem_in_o <= mdm_i;
			q_free_o <= qf_i;
			inbound_block_o <= ib_i;
		end
	end
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
	import dls_pkg::*;
	logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, ib = 0;
	logic [7:0] adr = 0, mo, txd;
	logic [31:0] dat = 0, q, r, dat_o, s = 32'h73931841;
	logic [3:0] sel = 4'hf, seen = 0;
	logic ack, brk, txv, ibo;
	logic [4:0] mdm = 0, mi;
	logic [15:0] qf = 0, qfo, e;
	logic [15:0] qt[6] = '{0, 5, 6, 7, 255, 256};
	dls_link_cmd_t cmd;
	dls_rd_end_t ev = '0, rde;
	int err_total = 0, check_count = 0, nbk = 0, cv;
	dls_line_status #(.QW(16), .BRK_UNIT_CYC(4)) i_dls_line_status(
		.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat),
		.wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .modem_in_i(mi),
		.modem_out_o(mo), .break_o(brk), .tx_data_o(txd),
		.tx_valid_o(txv), .link_cmd_o(cmd), .rd_end_i(rde),
		.inbound_block_i(ibo), .q_free_i(qfo));
	dls_modem_model i_dls_modem_model(.clk_i(clk_i), .rst_i(rst_i),
		.ev_i(ev), .mdm_i(mdm), .qf_i(qf), .ib_i(ib), .rd_end_o(rde),
		.modem_in_o(mi), .q_free_o(qfo), .inbound_block_o(ibo));
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		seen = seen | cmd;
		if (brk === 1'b1) nbk++;
	end
	function automatic logic [31:0] rnd();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [15:0] cbx(int c, int k, logic [3:0] h);
		if (c[0]) return k == 7 ? 16'hfe01 : k == 8 ? 16'hfe02 :
			k == 9 ? {12'hfd0, h} : 16'h0;
		if (k >= 2 && k <= 4) return c[3] ? 16'h0 : {8'hfb, 8'(k - 1)};
		return k == 1 ? 16'hfa00 : k == 5 ? 16'hfc01 :
			k == 6 ? 16'hfd01 : 16'h0;
	endfunction
	task chk(input logic [31:0] a, input logic [31:0] x);
		check_count++;
		if (a !== x) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, a, x);
		end
	endtask
	// Values stay within 0 to 255 because only eight bits are sent.
	task wb(input logic [5:0] i, input logic w, input logic [7:0] d);
		adr <= {i, 2'b00};
		we <= w;
		dat <= {24'h0, d};
		cyc <= 1;
		stb <= 1;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = dat_o;
		cyc <= 0;
		stb <= 0;
		we <= 0;
		@(posedge clk_i);
	endtask
	task rd(input logic [5:0] i, input logic [31:0] x);
		wb(i, 0, 0);
		chk(q, x);
	endtask
	task finish_test;
		$display("errors %0d checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		finish_test;
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		rd(6'h08, 0);
		rd(6'h09, 0);
		rd(6'h0a, 0);
		rd(6'h06, 0);
		rd(6'h27, 1);
		rd(6'h3f, 0);
		for (int i = 0; i < 14; i++) begin
			r = rnd();
			mdm <= r[4:0];
			qf <= i < 6 ? qt[i] : r[31:16];
			repeat (2) @(posedge clk_i);
			rd(6'h07, {27'h0, mdm});
			rd(6'h0b, qf < 6 ? 0 : qf > 255 ? 255 : qf);
		end
		wb(6'h22, 1, 8'h06);
		wb(6'h21, 1, 8'hc2);
		rd(6'h21, 32'hc2);
		rd(6'h22, 32'h06);
		rd(6'h08, 32'hc3);
		chk(mo, 8'hc3);
		seen = 0;
		wb(6'h05, 1, 0);
		chk(seen, 4'h1);
		rd(6'h08, 32'hc2);
		r = rnd();
		wb(6'h20, 1, r[7:0]);
		chk(txd, r[7:0]);
		rd(6'h08, 32'hc3);
		wb(6'h22, 1, 8'h04);
		wb(6'h21, 1, r[7:0]);
		rd(6'h08, {24'h0, r[7:0]});
		seen = 0;
		wb(6'h05, 1, 0);
		chk(seen, 0);
		sel <= 4'he;
		wb(6'h21, 1, ~r[7:0]);
		sel <= 4'hf;
		rd(6'h08, {24'h0, r[7:0]});
		wb(6'h22, 1, 0);
		rd(6'h08, 0);
		wb(6'h27, 1, 8'h02);
		rd(6'h27, 32'h02);
		nbk = 0;
		wb(6'h06, 1, r[15:8]);
		rd(6'h06, 1);
		repeat (20) @(posedge clk_i);
		chk(nbk, 8);
		rd(6'h06, 0);
		wb(6'h22, 1, 8'h01);
		for (int i = 0; i < 3; i++) begin
			ib <= i == 0;
			repeat (2) @(posedge clk_i);
			seen = 0;
			wb(i < 2 ? 6'h06 : 6'h05, 1, 0);
			chk(seen, i == 0 ? 4'h4 : i == 1 ? 4'h2 : 4'h8);
		end
		rd(6'h06, 0);
		for (int c = 0; c < 3; c++) begin
			cv = c == 2 ? 8 : c;
			wb(6'h22, 1, 8'(cv));
			for (int k = 0; k < 10; k++) begin
				if (c == 2 && (k < 2 || k > 4)) continue;
				r = rnd();
				ev <= dls_rd_end_t'({1'b1, 4'(k), r[3:0]});
				@(posedge clk_i);
				ev <= '0;
				repeat (3) @(posedge clk_i);
				e = cbx(cv, k, {r[0], r[2:1], r[3]});
				rd(6'h09, e[15:8]);
				rd(6'h0a, e[7:0]);
			end
		end
		finish_test;
	end
endmodule
